/* core/cbt_pkg.sv */
`default_nettype none
package cbt_pkg;

    // Clock and bit timing, all in nanoseconds unless the name says otherwise.
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned BIT_PERIOD_NS      = 4000;
    localparam int unsigned BIT_MIN_NS         = 3970;
    localparam int unsigned BIT_MAX_NS         = 4030;
    localparam int unsigned BIT_CLKS_MIN       = (BIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BIT_CLKS_MAX       = BIT_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned QUANTUM_MAX_NS     = 400;
    localparam int unsigned QUANTUM_MAX_CLKS   = QUANTUM_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned NQ_MIN             = 10;
    localparam int unsigned NQ_MAX             = 22;
    localparam int unsigned SEG2_FLOOR_Q       = 2;

    // Network budget from which the per-quanta bounds below were derived.
    localparam int unsigned FREQ_DEV_PPM       = 7500;
    localparam int unsigned MEDIA_DELAY_MAX_NS = 800;
    localparam int unsigned NODE_LOOP_MIN_NS   = 50;
    localparam int unsigned NODE_LOOP_MAX_NS   = 390;
    localparam int unsigned PROP_MIN_NS        = 2 * NODE_LOOP_MIN_NS;
    localparam int unsigned PROP_MAX_NS        = 2 * (NODE_LOOP_MAX_NS + MEDIA_DELAY_MAX_NS);
    localparam int unsigned SJW_DRIFT_BITS     = 20;
    localparam int unsigned SEG2_DRIFT_BITS    = 25;

    // Register map.
    localparam logic [3:0] REG_QUANTUM_OFS  = 4'h0;
    localparam logic [3:0] REG_TIMING_OFS   = 4'h4;
    localparam logic [3:0] REG_STATUS_OFS   = 4'h8;
    localparam int unsigned TIM_NQ_LSB      = 0;
    localparam int unsigned TIM_SEG2_LSB    = 8;
    localparam int unsigned TIM_SJW_LSB     = 16;
    localparam int unsigned STAT_VALID_BIT  = 0;
    localparam int unsigned STAT_SAMPLE_BIT = 1;
    localparam int unsigned STAT_STATE_LSB  = 4;
    localparam int unsigned STAT_CLKS_LSB   = 16;

    // Reset setting: 20 quanta of 5 clocks, giving 100 clocks per bit.
    localparam logic [4:0] RST_PRESCALE = 5'h05;
    localparam logic [4:0] RST_NQ       = 5'h14;
    localparam logic [4:0] RST_SEG2     = 5'h04;
    localparam logic [3:0] RST_SJW      = 4'h4;

    typedef struct packed {
        logic [4:0] prescale;
        logic [4:0] nq;
        logic [4:0] seg2;
        logic [3:0] sjw;
    } cbt_cfg_t;

    typedef struct packed {
        logic strobe;
        logic value;
    } cbt_sample_t;

    typedef enum logic [1:0] {ST_SYNC, ST_SEG1, ST_SEG2} cbt_state_t;

    // Least jump width in quanta for each quanta count, from the drift and delay budget.
    function automatic logic [4:0] cbt_sjw_min_q(input logic [4:0] nq);
        cbt_sjw_min_q = (nq >= 5'h0F) ? 5'h04 : 5'h03;
    endfunction

    // Longest post-sample segment in quanta for each quanta count.
    function automatic logic [4:0] cbt_seg2_max_q(input logic [4:0] nq);
        case (nq)
            5'h16:               cbt_seg2_max_q = 5'h08;
            5'h13, 5'h14, 5'h15: cbt_seg2_max_q = 5'h07;
            5'h11, 5'h12:        cbt_seg2_max_q = 5'h06;
            5'h0F, 5'h10:        cbt_seg2_max_q = 5'h05;
            5'h0C, 5'h0D, 5'h0E: cbt_seg2_max_q = 5'h04;
            default:             cbt_seg2_max_q = 5'h03;
        endcase
    endfunction

endpackage
`default_nettype wire

/* core/cbt_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module cbt_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

/* core/cbt_quantum_div.sv */
`timescale 1ns/1ps
`default_nettype none
module cbt_quantum_div #(
    parameter int unsigned W = 5
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         restart,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Greater-or-equal keeps the count from running round when the divider shrinks mid-count.
    assign tick = !restart && (cnt_q >= div - W'(1));

    always_comb begin
        if (restart || tick) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* core/cbt_bit_timing.sv */
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - one bus sample per bit, no voting
// - sample at bit minus post-sample segment
// - bit period 4000 ns within 3970..4030
// - bit period is whole system clocks, programmable
// - pre-sample equals bit minus one minus post
// - post-sample at least jump width and two
// - ten to twenty-two quanta per bit
// - quantum no longer than 400 ns
// - jump width meets drift and delay floor
// - post-sample within drift and round-trip ceiling
// - bounds assume 4000 ns, error in deviation
// - tolerate round trip of loop plus media
// - media 800 ns, node loop 50..390 ns
// - deviation term is 0.75 percent
// - sync segment lasts exactly one quantum; skipped after hard sync or early end
// - edges stretch or shrink within jump width
// - quantum from system clock by divider
module cbt_bit_timing (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WE,
    input  wire logic        REG_RE,
    output logic      [31:0] REG_RDATA,
    input  wire logic        RX_PIN,
    input  wire logic        CTRL_IDLE,
    output logic             SAMPLE_STROBE,
    output logic             SAMPLE_BIT,
    output logic             BIT_START
);
    cbt_pkg::cbt_cfg_t    prog_q, prog_d;
    cbt_pkg::cbt_cfg_t    act_q, act_d;
    cbt_pkg::cbt_state_t  state_q, state_d;
    cbt_pkg::cbt_sample_t samp_q, samp_d;
    logic [31:0]          rdata_q, rdata_d;
    logic [4:0]           tq_cnt_q, tq_cnt_d;
    logic [5:0]           seg1_len_q, seg1_len_d;
    logic [4:0]           seg2_len_q, seg2_len_d;
    logic                 synced_q, synced_d;
    logic                 bit_start_q, bit_start_d;
    logic                 rx_prev_q;
    logic                 rx_s;
    logic                 fall_edge;
    logic                 tq_tick;
    logic                 restart;
    logic                 cfg_valid;
    logic [9:0]           bit_clks;
    logic [4:0]           prog_seg1;
    logic [4:0]           act_seg1;

    // Local aliases for the package's state names, since nothing is imported.
    localparam cbt_pkg::cbt_state_t ST_SYNC = cbt_pkg::ST_SYNC;
    localparam cbt_pkg::cbt_state_t ST_SEG1 = cbt_pkg::ST_SEG1;
    localparam cbt_pkg::cbt_state_t ST_SEG2 = cbt_pkg::ST_SEG2;

    // Bus input passes two flip-flops before any logic sees it.
    cbt_sync2 #(
        .RST_VAL (1'b1)
    ) u_rx_sync (
        .clk      (CLK),
        .rst_n    (RST_N),
        .async_in (RX_PIN),
        .sync_out (rx_s)
    );

    cbt_quantum_div #(
        .W (5)
    ) u_div (
        .clk     (CLK),
        .rst_n   (RST_N),
        .restart (restart),
        .div     (act_q.prescale),
        .tick    (tq_tick)
    );

    assign fall_edge = rx_prev_q & ~rx_s;
    assign prog_seg1 = prog_q.nq - 5'h01 - prog_q.seg2;
    assign act_seg1  = act_q.nq - 5'h01 - act_q.seg2;
    assign bit_clks  = 10'(prog_q.prescale) * 10'(prog_q.nq);

    // The quanta bounds come from the drift, deviation and round-trip budget at a 4000 ns bit.
    always_comb begin
        cfg_valid = 1'b1;
        if (bit_clks < 10'(cbt_pkg::BIT_CLKS_MIN) || bit_clks > 10'(cbt_pkg::BIT_CLKS_MAX)) begin
            cfg_valid = 1'b0;
        end
        if (prog_q.nq < 5'(cbt_pkg::NQ_MIN) || prog_q.nq > 5'(cbt_pkg::NQ_MAX)) begin
            cfg_valid = 1'b0;
        end
        if (prog_q.prescale == 5'h00 || prog_q.prescale > 5'(cbt_pkg::QUANTUM_MAX_CLKS)) begin
            cfg_valid = 1'b0;
        end
        if (prog_q.seg2 < {1'b0, prog_q.sjw} || prog_q.seg2 < 5'(cbt_pkg::SEG2_FLOOR_Q)) begin
            cfg_valid = 1'b0;
        end
        if ({1'b0, prog_q.sjw} < cbt_pkg::cbt_sjw_min_q(prog_q.nq)) begin
            cfg_valid = 1'b0;
        end
        if (prog_q.seg2 > cbt_pkg::cbt_seg2_max_q(prog_q.nq)) begin
            cfg_valid = 1'b0;
        end
        if (prog_seg1 == 5'h00) begin
            cfg_valid = 1'b0;
        end
    end

    // Software writes land in the programmed copy; the timing engine only sees the active copy.
    always_comb begin
        prog_d = prog_q;
        if (REG_WE && REG_ADDR == cbt_pkg::REG_QUANTUM_OFS) begin
            prog_d.prescale = REG_WDATA[4:0];
        end
        if (REG_WE && REG_ADDR == cbt_pkg::REG_TIMING_OFS) begin
            prog_d.nq   = REG_WDATA[cbt_pkg::TIM_NQ_LSB +: 5];
            prog_d.seg2 = REG_WDATA[cbt_pkg::TIM_SEG2_LSB +: 5];
            prog_d.sjw  = REG_WDATA[cbt_pkg::TIM_SJW_LSB +: 4];
        end
        act_d = act_q;
        if (CTRL_IDLE && cfg_valid) begin
            act_d = prog_q;
        end
        rdata_d = 32'h0000_0000;
        if (REG_RE) begin
            case (REG_ADDR)
                cbt_pkg::REG_QUANTUM_OFS: begin
                    rdata_d[4:0] = prog_q.prescale;
                end
                cbt_pkg::REG_TIMING_OFS: begin
                    rdata_d[cbt_pkg::TIM_NQ_LSB +: 5]   = prog_q.nq;
                    rdata_d[cbt_pkg::TIM_SEG2_LSB +: 5] = prog_q.seg2;
                    rdata_d[cbt_pkg::TIM_SJW_LSB +: 4]  = prog_q.sjw;
                end
                cbt_pkg::REG_STATUS_OFS: begin
                    rdata_d[cbt_pkg::STAT_VALID_BIT]     = cfg_valid;
                    rdata_d[cbt_pkg::STAT_SAMPLE_BIT]    = samp_q.value;
                    rdata_d[cbt_pkg::STAT_STATE_LSB +: 2] = state_q;
                    rdata_d[cbt_pkg::STAT_CLKS_LSB +: 10] = bit_clks;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prog_q  <= '{cbt_pkg::RST_PRESCALE, cbt_pkg::RST_NQ, cbt_pkg::RST_SEG2, cbt_pkg::RST_SJW};
            act_q   <= '{cbt_pkg::RST_PRESCALE, cbt_pkg::RST_NQ, cbt_pkg::RST_SEG2, cbt_pkg::RST_SJW};
            rdata_q <= 32'h0000_0000;
        end else begin
            prog_q  <= prog_d;
            act_q   <= act_d;
            rdata_q <= rdata_d;
        end
    end

    // Only falling edges resynchronise, and only one per bit, as a node would sample its own echo.
    always_comb begin
        logic [5:0] s1;
        logic [4:0] s2;
        logic [5:0] ext;
        logic [4:0] left;
        s1           = seg1_len_q;
        s2           = seg2_len_q;
        ext          = 6'(tq_cnt_q) + 6'h01;
        left         = seg2_len_q - tq_cnt_q;
        state_d      = state_q;
        tq_cnt_d     = tq_cnt_q;
        synced_d     = synced_q;
        samp_d       = '{strobe: 1'b0, value: samp_q.value};
        bit_start_d  = 1'b0;
        restart      = 1'b0;
        if (ext > 6'(act_q.sjw)) begin
            ext = 6'(act_q.sjw);
        end
        if (fall_edge && CTRL_IDLE && state_q != ST_SYNC) begin
            // Hard sync: the edge itself is the sync segment.
            state_d     = ST_SEG1;
            tq_cnt_d    = 5'h00;
            s1          = 6'(act_seg1);
            s2          = act_q.seg2;
            synced_d    = 1'b1;
            restart     = 1'b1;
            bit_start_d = 1'b1;
        end else if (fall_edge && !synced_q && state_q == ST_SEG2 && left <= 5'(act_q.sjw)) begin
            state_d     = ST_SEG1;
            tq_cnt_d    = 5'h00;
            s1          = 6'(act_seg1);
            s2          = act_q.seg2;
            synced_d    = 1'b1;
            restart     = 1'b1;
            bit_start_d = 1'b1;
        end else begin
            if (fall_edge && !synced_q && state_q == ST_SEG1) begin
                s1       = seg1_len_q + ext;
                synced_d = 1'b1;
            end
            if (fall_edge && !synced_q && state_q == ST_SEG2) begin
                s2       = seg2_len_q - 5'(act_q.sjw);
                synced_d = 1'b1;
            end
            if (tq_tick) begin
                case (state_q)
                    ST_SYNC: begin
                        state_d  = ST_SEG1;
                        tq_cnt_d = 5'h00;
                        s1       = 6'(act_seg1);
                        s2       = act_q.seg2;
                    end
                    ST_SEG1: begin
                        if (6'(tq_cnt_q) + 6'h01 >= s1) begin
                            state_d  = ST_SEG2;
                            tq_cnt_d = 5'h00;
                            samp_d   = '{strobe: 1'b1, value: rx_s};
                        end else begin
                            tq_cnt_d = tq_cnt_q + 5'h01;
                        end
                    end
                    ST_SEG2: begin
                        if (tq_cnt_q + 5'h01 >= s2) begin
                            state_d     = ST_SYNC;
                            tq_cnt_d    = 5'h00;
                            synced_d    = 1'b0;
                            bit_start_d = 1'b1;
                        end else begin
                            tq_cnt_d = tq_cnt_q + 5'h01;
                        end
                    end
                    default: begin
                        state_d = ST_SYNC;
                    end
                endcase
            end
        end
        seg1_len_d = s1;
        seg2_len_d = s2;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q     <= ST_SYNC;
            tq_cnt_q    <= 5'h00;
            seg1_len_q  <= 6'h00;
            seg2_len_q  <= 5'h00;
            synced_q    <= 1'b0;
            samp_q      <= '{strobe: 1'b0, value: 1'b1};
            bit_start_q <= 1'b0;
            rx_prev_q   <= 1'b1;
        end else begin
            state_q     <= state_d;
            tq_cnt_q    <= tq_cnt_d;
            seg1_len_q  <= seg1_len_d;
            seg2_len_q  <= seg2_len_d;
            synced_q    <= synced_d;
            samp_q      <= samp_d;
            bit_start_q <= bit_start_d;
            rx_prev_q   <= rx_s;
        end
    end

    assign REG_RDATA     = rdata_q;
    assign SAMPLE_STROBE = samp_q.strobe;
    assign SAMPLE_BIT    = samp_q.value;
    assign BIT_START     = bit_start_q;

    // Checking helpers.
    logic [1:0] samp_in_bit_q;
    logic [5:0] sync_cyc_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            samp_in_bit_q <= 2'h0;
            sync_cyc_q    <= 6'h00;
        end else begin
            if (bit_start_q) begin
                samp_in_bit_q <= 2'h0;
            end else if (samp_q.strobe && samp_in_bit_q != 2'h3) begin
                samp_in_bit_q <= samp_in_bit_q + 2'h1;
            end
            sync_cyc_q <= (state_q == ST_SYNC) ? sync_cyc_q + 6'h01 : 6'h00;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_one_sample_per_bit;
        samp_in_bit_q <= 2'h1;
    endproperty
    a_one_sample_per_bit: assert property (p_one_sample_per_bit) else $error("two samples in one bit");

    property p_sample_at_seg_change;
        ($past(state_q) == ST_SEG1 && state_q == ST_SEG2) |-> SAMPLE_STROBE;
    endproperty
    a_sample_at_seg_change: assert property (p_sample_at_seg_change) else $error("sample missed");

    property p_valid_period;
        cfg_valid |-> bit_clks == 10'(cbt_pkg::BIT_CLKS_MIN);
    endproperty
    a_valid_period: assert property (p_valid_period) else $error("bad bit period accepted");

    property p_valid_seg2;
        cfg_valid |-> (prog_q.seg2 >= {1'b0, prog_q.sjw}) && (prog_q.seg2 >= 5'h02);
    endproperty
    a_valid_seg2: assert property (p_valid_seg2) else $error("short post segment accepted");

    property p_valid_nq_quantum;
        cfg_valid |-> prog_q.nq >= 5'h0A && prog_q.nq <= 5'h16 && prog_q.prescale <= 5'h0A;
    endproperty
    a_valid_nq_quantum: assert property (p_valid_nq_quantum) else $error("bad quanta accepted");

    property p_sync_one_quantum;
        (state_q == ST_SEG1 && $past(state_q) == ST_SYNC && $stable(act_q))
            |-> sync_cyc_q == 6'(act_q.prescale);
    endproperty
    a_sync_one_quantum: assert property (p_sync_one_quantum) else $error("sync length wrong");

    property p_stretch_limit;
        (state_q == ST_SEG1 && $past(state_q) == ST_SEG1 && seg1_len_q != $past(seg1_len_q))
            |-> seg1_len_q - $past(seg1_len_q) <= 6'(act_q.sjw);
    endproperty
    a_stretch_limit: assert property (p_stretch_limit) else $error("stretch beyond jump");

    property p_shrink_limit;
        (state_q == ST_SEG2 && $past(state_q) == ST_SEG2 && seg2_len_q != $past(seg2_len_q))
            |-> $past(seg2_len_q) - seg2_len_q == 5'(act_q.sjw);
    endproperty
    a_shrink_limit: assert property (p_shrink_limit) else $error("shrink not jump width");

    property p_strobe_pulse;
        SAMPLE_STROBE |=> !SAMPLE_STROBE;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("sample strobe too long");

    property p_reload_idle;
        !$past(CTRL_IDLE) |-> $stable(act_q);
    endproperty
    a_reload_idle: assert property (p_reload_idle) else $error("reload while busy");

    c_sample: cover property (SAMPLE_STROBE ##[1:200] SAMPLE_STROBE);
    c_hard_sync: cover property (fall_edge && CTRL_IDLE && state_q == ST_SEG2);
    c_stretch: cover property (fall_edge && !synced_q && state_q == ST_SEG1);
    c_shrink: cover property (fall_edge && !synced_q && state_q == ST_SEG2 && !CTRL_IDLE);
endmodule
`default_nettype wire

/* verif/cbt_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Other nodes on the bus, seen through the transceiver.
// The bus idles recessive and changes only at a chosen clock offset into the bit.
// A late offset stands in for a slow or distant node.
module cbt_bus_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bit_start,
    input  wire logic       next_bit,
    input  wire logic [7:0] change_at,
    output logic            rx
);
    logic [7:0] cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            rx  <= 1'b1;
        end else begin
            cnt <= bit_start ? 8'h00 : cnt + 8'h01;
            if (cnt == change_at) begin
                rx <= next_bit;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/can_bit_timing_250k_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_250k_tb;
    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic [3:0]  reg_addr    = 4'h0;
    logic [31:0] reg_wdata   = 32'h0;
    logic        reg_we      = 1'b0;
    logic        reg_re      = 1'b0;
    logic        ctrl_idle   = 1'b1;
    logic        next_bit    = 1'b1;
    logic [7:0]  change_at   = 8'h61;
    logic [31:0] reg_rdata;
    logic        rx_pin;
    logic        sample_strobe;
    logic        sample_bit;
    logic        bit_start;
    logic        re_d        = 1'b0;
    logic        chk_time    = 1'b0;
    logic        chk_val     = 1'b0;
    logic        r;
    logic [63:0] e;
    logic [63:0] rd_q[$];
    logic        bit_q[$];
    logic [31:0] bad_tim[5] = '{32'h00040114, 32'h00050414, 32'h00040914,
                                32'h00030414, 32'h00040415};
    int          n_fail      = 0;
    int          check_count = 0;
    integer      seed        = 32'hb43f66e6;
    int unsigned cyc         = 0;
    int unsigned last_start  = 0;
    int unsigned n_samp      = 0;
    int unsigned exp_off     = 80;
    int unsigned lo          = 100;
    int unsigned hi          = 100;

    always #20 clk = ~clk;

    cbt_bit_timing uut (
        .CLK           (clk),
        .RST_N         (rst_n),
        .REG_ADDR      (reg_addr),
        .REG_WDATA     (reg_wdata),
        .REG_WE        (reg_we),
        .REG_RE        (reg_re),
        .REG_RDATA     (reg_rdata),
        .RX_PIN        (rx_pin),
        .CTRL_IDLE     (ctrl_idle),
        .SAMPLE_STROBE (sample_strobe),
        .SAMPLE_BIT    (sample_bit),
        .BIT_START     (bit_start)
    );

    cbt_bus_model bus (
        .clk       (clk),
        .rst_n     (rst_n),
        .bit_start (bit_start),
        .next_bit  (next_bit),
        .change_at (change_at),
        .rx        (rx_pin)
    );

    task automatic report_and_stop();
        $display("Checks %0d, failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
        @(posedge clk);
        rd_q.push_back({x, m});
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
    endtask

    // Returns one cycle after the n-th bit start, so the monitor has already seen it.
    task automatic wait_starts(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (bit_start !== 1'b1 && k < 400);
            if (k >= 400) begin
                cmp(32'h0, 32'h1);
                report_and_stop();
            end
        end
        @(posedge clk);
    endtask

    task automatic set_bus(input logic b, input logic [7:0] at, input int unsigned l,
                           input int unsigned h, input int n);
        next_bit  <= b;
        change_at <= at;
        lo        = l;
        hi        = h;
        wait_starts(n);
    endtask

    // Results side: read data, sample values and bit timing are taken off as they appear.
    always @(posedge clk) begin
        cyc++;
        re_d <= reg_re;
        if (re_d && rd_q.size() > 0) begin
            e = rd_q.pop_front();
            cmp(reg_rdata & e[31:0], e[63:32]);
        end else begin
            cmp(reg_rdata, 32'h0);
        end
        if (sample_strobe === 1'b1) begin
            n_samp++;
            if (chk_time && lo == hi) cmp(cyc - last_start, exp_off);
            if (chk_val && bit_q.size() > 0) begin
                cmp({31'h0, sample_bit}, {31'h0, bit_q.pop_front()});
                r = $random(seed);
                next_bit <= r;
                bit_q.push_back(r);
            end
        end
        if (bit_start === 1'b1) begin
            if (chk_time) begin
                cmp({31'h0, (cyc - last_start >= lo) && (cyc - last_start <= hi)}, 32'h1);
                if (lo == hi) cmp(n_samp, 32'h1);
            end
            last_start = cyc;
            n_samp     = 0;
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(cbt_pkg::REG_QUANTUM_OFS, 32'h00000005, 32'hFFFFFFFF);
        rd(cbt_pkg::REG_TIMING_OFS, 32'h00040414, 32'hFFFFFFFF);
        rd(cbt_pkg::REG_STATUS_OFS, 32'h00640001, 32'h03FF0001);
        rd(4'hC, 32'h0, 32'hFFFFFFFF);
        wait_starts(2);
        chk_time = 1'b1;
        bit_q.push_back(next_bit);
        chk_val = 1'b1;
        wait_starts(20);
        chk_val = 1'b0;
        // Busy frame logic: late and early falling edges resynchronise within the jump width.
        ctrl_idle <= 1'b0;
        set_bus(1'b1, 8'h61, 100, 100, 2);
        set_bus(1'b0, 8'h28, 101, 120, 1);
        set_bus(1'b1, 8'h28, 100, 100, 2);
        set_bus(1'b0, 8'h5A, 80, 99, 1);
        // The bit after an early end has no sync segment, so it is one quantum short.
        exp_off = 75;
        set_bus(1'b0, 8'h61, 95, 95, 1);
        exp_off = 80;
        set_bus(1'b0, 8'h61, 100, 100, 2);
        // Idle frame logic: a falling edge mid-bit restarts the bit at once.
        ctrl_idle <= 1'b1;
        set_bus(1'b1, 8'h61, 100, 100, 2);
        set_bus(1'b0, 8'h28, 42, 48, 1);
        set_bus(1'b0, 8'h61, 95, 100, 1);
        set_bus(1'b0, 8'h61, 100, 100, 2);
        cmp({31'h0, sample_bit}, 32'h0);
        // Ten quanta of ten clocks; a half-written setting never goes live.
        chk_time = 1'b0;
        wr(cbt_pkg::REG_QUANTUM_OFS, 32'h0000000A);
        wr(cbt_pkg::REG_TIMING_OFS, 32'h0003030A);
        rd(cbt_pkg::REG_STATUS_OFS, 32'h00640001, 32'h03FF0001);
        wait_starts(2);
        exp_off  = 70;
        chk_time = 1'b1;
        wait_starts(3);
        ctrl_idle <= 1'b0;
        wr(cbt_pkg::REG_QUANTUM_OFS, 32'h00000005);
        wr(cbt_pkg::REG_TIMING_OFS, 32'h00040414);
        wait_starts(3);
        chk_time = 1'b0;
        ctrl_idle <= 1'b1;
        wait_starts(2);
        exp_off  = 80;
        chk_time = 1'b1;
        wait_starts(2);
        foreach (bad_tim[i]) begin
            wr(cbt_pkg::REG_TIMING_OFS, bad_tim[i]);
            rd(cbt_pkg::REG_TIMING_OFS, bad_tim[i], 32'hFFFFFFFF);
            rd(cbt_pkg::REG_STATUS_OFS, 32'h0, 32'h00000001);
        end
        wait_starts(3);
        wr(cbt_pkg::REG_TIMING_OFS, 32'h00040414);
        wait_starts(1);
        report_and_stop();
    end
endmodule
`default_nettype wire
